// >>> rtl/pdc_engine.v
// Device command engine for PIO data-out and DMA command classes
//
// Summary of operation
// - Prepare: BSY set, DRQ clear, INTRQ negated
// - First block: transfer directly, no interrupt
// - Later block: set pending, nIEN picks state
// - Ready-interrupt state: BSY0, DRQ1, INTRQ asserted
// - Status read there clears pending, to transfer
// - Transfer: BSY0, DRQ1, no INTRQ, accept words
// - Completion/abort: pending, errors, clear BSY, idle
// - DMA command sets pending exactly once; INTRQ only with nIEN clear
// - DMA prepare: BSY set, DRQ clear, INTRQ off
// - DMA prepare abort: errors, pending, idle
// - DMA transfer: INTRQ off, BSY/DRQ valid pair
// - Early burst end returns to prepare
// - DMA done or abort: errors, pending, idle
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pdc_defs.vh"
module pdc_engine (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        blk_ready,
    input  wire        dev_abort,
    input  wire [7:0]  dev_err_code,
    input  wire        dma_word,
    input  wire        dma_stop,
    output reg  [15:0] wr_data,
    output reg         wr_valid,
    output reg         dma_dir_in,
    output wire        dmarq,
    output wire        intrq,
    output wire        busy
);
    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_PIO_PREP = 3'h1;
    localparam [2:0] ST_PIO_XFER = 3'h2;
    localparam [2:0] ST_PIO_RDYI = 3'h3;
    localparam [2:0] ST_DMA_PREP = 3'h4;
    localparam [2:0] ST_DMA_XFER = 3'h5;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [31:0] count_cfg;
    reg         nien;
    reg         int_pend;
    reg         err_flag;
    reg  [7:0]  err_code;
    reg         first_blk;
    reg         sw_abort;

    wire        acc      = psel & penable;
    wire        wr_acc   = acc & pwrite;
    wire        rd_acc   = acc & ~pwrite;
    wire        sel_cmd  = (paddr == `PDC_ADDR_CMD);
    wire        sel_cnt  = (paddr == `PDC_ADDR_COUNT);
    wire        sel_ctrl = (paddr == `PDC_ADDR_CTRL);
    wire        sel_st   = (paddr == `PDC_ADDR_STATUS);
    wire        sel_alt  = (paddr == `PDC_ADDR_ALTSTAT);
    wire        sel_data = (paddr == `PDC_ADDR_DATA);
    wire        sel_err  = (paddr == `PDC_ADDR_ERROR);
    wire        mapped   = sel_cmd | sel_cnt | sel_ctrl | sel_st |
                           sel_alt | sel_data | sel_err;
    wire        idle     = (state == ST_IDLE);
    wire        bad_cmd  = sel_cmd & (!idle | (count_cfg[`PDC_CNT_WORDS] == 16'h0000));
    wire        cmd_go   = wr_acc & sel_cmd & !bad_cmd;
    wire        is_dma   = pwdata[`PDC_CMD_DMA];
    wire        st_read  = rd_acc & sel_st;
    wire        data_wr  = wr_acc & sel_data & (state == ST_PIO_XFER);
    wire        abort    = dev_abort | sw_abort;

    assign pready  = 1'b1;
    assign pslverr = acc & (!mapped | (pwrite & bad_cmd));

    // Word and block counters
    wire [15:0] words_left;
    wire [15:0] blocks_left;
    wire        word_last;
    wire        block_last;
    wire        blocks_zero;
    wire        dma_move = dma_word & (state == ST_DMA_XFER);
    wire        word_step = data_wr | dma_move;
    wire        blk_end  = word_step & word_last;
    reg         word_load;

    always @* begin
        word_load = cmd_go | blk_end;
    end

    pdc_count u_words (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (word_load),
        .load_val (count_cfg[`PDC_CNT_WORDS]),
        .dec      (word_step),
        .count    (words_left),
        .is_last  (word_last),
        .is_zero  ()
    );

    pdc_count u_blocks (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (cmd_go),
        .load_val (count_cfg[`PDC_CNT_BLOCKS]),
        .dec      (blk_end),
        .count    (blocks_left),
        .is_last  (block_last),
        .is_zero  (blocks_zero)
    );

    wire        dma_done = blk_end & block_last & (state == ST_DMA_XFER);

    // Next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmd_go) begin
                    next_state = is_dma ? ST_DMA_PREP : ST_PIO_PREP;
                end
            end
            ST_PIO_PREP: begin
                if (abort || blocks_zero) begin
                    next_state = ST_IDLE;
                end else if (blk_ready) begin
                    if (first_blk || nien) begin
                        next_state = ST_PIO_XFER;
                    end else begin
                        next_state = ST_PIO_RDYI;
                    end
                end
            end
            ST_PIO_RDYI: begin
                if (st_read) begin
                    next_state = ST_PIO_XFER;
                end
            end
            ST_PIO_XFER: begin
                if (blk_end) begin
                    next_state = ST_PIO_PREP;
                end
            end
            ST_DMA_PREP: begin
                if (abort || blocks_zero) begin
                    next_state = ST_IDLE;
                end else if (blk_ready) begin
                    next_state = ST_DMA_XFER;
                end
            end
            ST_DMA_XFER: begin
                if (abort || dma_done) begin
                    next_state = ST_IDLE;
                end else if (dma_stop) begin
                    next_state = ST_DMA_PREP;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Interrupt pending set conditions
    wire pio_more = (state == ST_PIO_PREP) & !abort & !blocks_zero &
                    blk_ready & !first_blk;
    wire pio_end  = (state == ST_PIO_PREP) & (abort | blocks_zero);
    wire dma_end  = ((state == ST_DMA_PREP) & (abort | blocks_zero)) |
                    ((state == ST_DMA_XFER) & (abort | dma_done));
    wire pend_set = pio_more | pio_end | dma_end;
    wire end_err  = (pio_end | dma_end) & abort;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            count_cfg <= `PDC_RST_COUNT;
            nien      <= `PDC_RST_NIEN;
            sw_abort  <= 1'b0;
            int_pend  <= 1'b0;
            err_flag  <= 1'b0;
            err_code  <= 8'h00;
            first_blk <= 1'b0;
            dma_dir_in <= 1'b0;
            wr_data   <= 16'h0000;
            wr_valid  <= 1'b0;
        end else begin
            state <= next_state;
            if (wr_acc && sel_cnt && idle) begin
                count_cfg <= pwdata;
            end
            if (wr_acc && sel_ctrl) begin
                nien <= pwdata[`PDC_CTRL_NIEN];
            end
            // Abort request set only while a command runs; a set wins over the clear on return to idle
            if (wr_acc && sel_ctrl && pwdata[`PDC_CTRL_ABORT] && !idle) begin
                sw_abort <= 1'b1;
            end else if (cmd_go || (next_state == ST_IDLE)) begin
                sw_abort <= 1'b0;
            end
            // Set wins over the clear by a status read
            if (cmd_go) begin
                int_pend <= 1'b0;
            end else if (pend_set) begin
                int_pend <= 1'b1;
            end else if (st_read) begin
                int_pend <= 1'b0;
            end
            if (cmd_go) begin
                err_flag <= 1'b0;
                err_code <= 8'h00;
                first_blk <= 1'b1;
                dma_dir_in <= pwdata[`PDC_CMD_DIR];
            end else begin
                if (end_err) begin
                    err_flag <= 1'b1;
                    err_code <= dev_abort ? dev_err_code : `PDC_SW_ABORT_CODE;
                end
                if (state == ST_PIO_XFER) begin
                    first_blk <= 1'b0;
                end
            end
            wr_valid <= data_wr;
            if (data_wr) begin
                wr_data <= pwdata[15:0];
            end
        end
    end

    // Pin and status views
    wire xfer_st = (state == ST_PIO_XFER) | (state == ST_PIO_RDYI) |
                   (state == ST_DMA_XFER);
    assign busy  = !idle & !xfer_st;
    assign dmarq = (state == ST_DMA_XFER) & !abort & !dma_stop;
    assign intrq = int_pend & !nien &
                   (idle | (state == ST_PIO_RDYI));

    wire [31:0] status_word = (32'h0000_0000 |
                               ({31'h0, busy}     << `PDC_ST_BSY) |
                               ({31'h0, xfer_st}  << `PDC_ST_DRQ) |
                               ({31'h0, dmarq}    << `PDC_ST_DMARQ) |
                               ({31'h0, int_pend} << `PDC_ST_PEND) |
                               ({31'h0, err_flag} << `PDC_ST_ERR));

    // Read data captured in the setup cycle
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h0000_0000;
        if (sel_cnt) begin
            next_prdata = count_cfg;
        end else if (sel_ctrl) begin
            next_prdata = {30'h0, sw_abort, nien};
        end else if (sel_st || sel_alt) begin
            next_prdata = status_word;
        end else if (sel_err) begin
            next_prdata = {24'h0, err_code};
        end else if (sel_cmd) begin
            next_prdata = {16'h0, blocks_left};
        end else if (sel_data) begin
            next_prdata = {16'h0, words_left};
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule

// >>> rtl/pdc_defs.vh
// Constants for the PIO data-out and DMA command engine
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// Register byte addresses
`define PDC_ADDR_CMD     8'h00
`define PDC_ADDR_COUNT   8'h04
`define PDC_ADDR_CTRL    8'h08
`define PDC_ADDR_STATUS  8'h0c
`define PDC_ADDR_ALTSTAT 8'h10
`define PDC_ADDR_DATA    8'h14
`define PDC_ADDR_ERROR   8'h18

// Command register fields
`define PDC_CMD_DMA      0
`define PDC_CMD_DIR      1

// Count register fields
`define PDC_CNT_WORDS    15:0
`define PDC_CNT_BLOCKS   31:16

// Control register fields
`define PDC_CTRL_NIEN    0
`define PDC_CTRL_ABORT   1

// Status register bit positions
`define PDC_ST_ERR       0
`define PDC_ST_PEND      1
`define PDC_ST_DMARQ     2
`define PDC_ST_DRQ       3
`define PDC_ST_BSY       7

// Reset values
`define PDC_RST_COUNT    32'h0001_0001
`define PDC_RST_NIEN     1'b0

// Error code reported for a software abort
`define PDC_SW_ABORT_CODE 8'hff

// Timing: latest BSY set after command write, 8 ns clock
`define PDC_BSY_MAX_NS   400
`define PDC_CLK_NS       8
`define PDC_BSY_MAX_CYC  (`PDC_BSY_MAX_NS / `PDC_CLK_NS)

`endif

// >>> rtl/pdc_count.v
// Loadable down counter for words and blocks
`timescale 1ns/1ps
module pdc_count (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        load,
    input  wire [15:0] load_val,
    input  wire        dec,
    output reg  [15:0] count,
    output wire        is_last,
    output wire        is_zero
);
    assign is_last = (count == 16'h0001);
    assign is_zero = (count == 16'h0000);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
        end else if (load) begin
            count <= load_val;
        end else if (dec && !is_zero) begin
            count <= count - 16'h0001;
        end
    end
endmodule

// >>> bench/pdc_engine_assertions.sv
// Port-level checks for the command engine
`timescale 1ns/1ps
module pdc_engine_assertions (
    input wire        core_clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    input wire [15:0] wr_data,
    input wire        wr_valid,
    input wire        dmarq,
    input wire        intrq,
    input wire        busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire acc = psel & penable;
    a_bsy_on_cmd: assert property (acc && pwrite && paddr == 8'h00
        && !busy && !pslverr |=> busy) else $error("busy not raised by command");
    a_cmd_refused: assert property (acc && pwrite && paddr == 8'h00 && busy
        |-> pslverr) else $error("command accepted while busy");
    a_quiet_busy: assert property (busy |-> !intrq)
        else $error("interrupt while busy");
    a_dma_quiet: assert property (dmarq |-> !intrq)
        else $error("interrupt during dma transfer");
    a_word_once: assert property (wr_valid |=> !wr_valid)
        else $error("word strobe too long");
    a_word_cause: assert property (wr_valid |-> $past(acc && pwrite && paddr == 8'h14)
        && wr_data == $past(pwdata[15:0])) else $error("word strobe without data write");
    a_rdy_cleared: assert property (acc && !pwrite && paddr == 8'h0c && intrq
        |=> !intrq) else $error("status read left interrupt up");
    a_intrq_idle: assert property ($rose(intrq) |-> !busy && !dmarq)
        else $error("interrupt raised in wrong state");
endmodule

// >>> bench/pdc_backend.sv
// Back-end model: block readiness and dma word strobes
`timescale 1ns/1ps
module pdc_backend (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       busy,
    input  wire       dmarq,
    input  wire [3:0] lag,
    input  wire       stop_req,
    output reg        blk_ready,
    output reg        dma_word,
    output reg        dma_stop
);
    reg [3:0] wait_cnt;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_cnt  <= 4'h0;
            blk_ready <= 1'b0;
            dma_word  <= 1'b0;
            dma_stop  <= 1'b0;
        end else begin
            wait_cnt  <= busy ? wait_cnt + {3'h0, wait_cnt != 4'hf} : 4'h0;
            blk_ready <= busy && wait_cnt >= lag;
            // Words move only while requested, channel set up before
            dma_word  <= dmarq && !dma_word && !stop_req;
            dma_stop  <= dmarq && stop_req && !dma_stop;
        end
    end
endmodule

// >>> bench/pdc_engine_tb.sv
// Self-checking bench for the command engine
`timescale 1ns/1ps
module pdc_engine_tb;
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        dev_abort = 0, stop_req = 0, iq_d = 0, er;
    logic [7:0]  paddr = 8'h00, dev_err_code = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, blk_ready, dma_word, dma_stop, wr_valid;
    logic        dma_dir_in, dmarq, intrq, busy;
    logic [15:0] wr_data;
    logic [3:0]  lag = 4'h0;
    int          error_cnt = 0, check_count = 0, rises = 0;
    pdc_engine u_pdc_engine (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .blk_ready(blk_ready),
        .dev_abort(dev_abort), .dev_err_code(dev_err_code), .dma_word(dma_word),
        .dma_stop(dma_stop), .wr_data(wr_data), .wr_valid(wr_valid),
        .dma_dir_in(dma_dir_in), .dmarq(dmarq), .intrq(intrq), .busy(busy));
    pdc_backend u_pdc_backend (.core_clk(core_clk), .rst(rst), .busy(busy),
        .dmarq(dmarq), .lag(lag), .stop_req(stop_req), .blk_ready(blk_ready),
        .dma_word(dma_word), .dma_stop(dma_stop));
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        iq_d <= intrq;
        if (intrq === 1'b1 && iq_d === 1'b0)
            rises <= rises + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll alternate status until a bit of m is set
    task automatic poll(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h10, 32'h0);
            n++;
        end while ((rd & m) == 32'h0 && n < 200);
        chk(n < 200, 1);
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0001_0001);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
    endtask
    task automatic t_pio(input logic nien);
        apb(1'b1, 8'h08, {31'h0, nien});
        apb(1'b1, 8'h04, 32'h0002_0002);
        apb(1'b1, 8'h00, 32'h0);
        chk(er, 0);
        repeat (50) @(posedge core_clk);
        for (int b = 0; b < 2; b++) begin
            poll(32'h08);
            chk(rd, b ? 32'h0a : 32'h08);
            chk(intrq, b && !nien);
            apb(1'b0, 8'h0c, 32'h0);
            @(posedge core_clk);
            chk(intrq, 0);
            for (int w = 0; w < 2; w++) begin
                apb(1'b1, 8'h14, 32'hbeef_1230 + b * 2 + w);
                @(negedge core_clk);
                chk(wr_valid, 1);
                chk(wr_data, 16'h1230 + b * 2 + w);
            end
        end
        poll(32'h02);
        chk(rd, 32'h02);
        chk(intrq, !nien);
        apb(1'b0, 8'h0c, 32'h0);
    endtask
    task automatic t_dma(input logic nien);
        int n, r0;
        logic seen;
        apb(1'b1, 8'h08, {31'h0, nien});
        apb(1'b1, 8'h04, 32'h0002_0003);
        r0 = rises;
        apb(1'b1, 8'h00, 32'h3);
        stop_req <= 1'b1;
        n = 0;
        seen = 1'b0;
        do begin
            @(posedge core_clk);
            seen = seen | (dmarq === 1'b1);
            n++;
        end while (dma_stop !== 1'b1 && n < 100);
        stop_req <= 1'b0;
        chk(n < 100, 1);
        chk(seen, 1);
        @(posedge core_clk);
        chk({busy, dma_dir_in}, 2'b11);
        repeat (50) @(posedge core_clk);
        poll(32'h02);
        chk(rd, 32'h02);
        chk(rises - r0, !nien);
        apb(1'b0, 8'h0c, 32'h0);
    endtask
    task automatic t_abort;
        lag <= 4'hf;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        chk(er, 1);
        dev_err_code <= 8'h5a;
        dev_abort <= 1'b1;
        @(posedge core_clk);
        dev_abort <= 1'b0;
        @(posedge core_clk);
        chk({busy, intrq}, 2'b01);
        repeat (50) @(posedge core_clk);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h5a);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h03);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h3);
        repeat (50) @(posedge core_clk);
        poll(32'h02);
        chk({intrq, rd}, {1'b0, 32'h03});
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'hff);
        lag <= 4'h0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_pio(1'b0);
        t_pio(1'b1);
        t_dma(1'b0);
        t_dma(1'b1);
        t_abort;
        conclude;
    end
endmodule
bind pdc_engine pdc_engine_assertions u_chk (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pslverr(pslverr), .wr_data(wr_data), .wr_valid(wr_valid), .dmarq(dmarq),
    .intrq(intrq), .busy(busy));
